// file: src/rscp_pkg.sv
// Constants and types for the reset source controller.
// Assumes a 200 MHz peripheral clock and a 32-bit APB register port.
package rscp_pkg;

  // Register indices and byte addresses (index times four)
  localparam logic [7:0] RSCP_IDX_CAUSE = 8'h00;
  localparam logic [7:0] RSCP_IDX_SOFT = 8'h01;
  // Byte address is the index shifted up by two; derived so each offset lives once
  localparam logic [7:0] RSCP_ADDR_CAUSE = {RSCP_IDX_CAUSE[5:0], 2'b00};
  localparam logic [7:0] RSCP_ADDR_SOFT = {RSCP_IDX_SOFT[5:0], 2'b00};

  // Cause flag and trigger bit positions
  localparam int RSCP_BIT_POWER_UP = 0;
  localparam int RSCP_BIT_SUPPLY_DIP = 1;
  localparam int RSCP_BIT_PIN = 2;
  localparam int RSCP_BIT_WATCHDOG = 3;
  localparam int RSCP_BIT_SOFTWARE = 4;
  localparam int RSCP_BIT_DEBUG_PORT = 5;
  localparam int RSCP_BIT_TRIGGER = 0;

  // Reset values
  localparam logic [5:0] RSCP_CAUSE_RESET = 6'h01;
  localparam logic [2:0] RSCP_UNLOCK_RESET = 3'h0;

  // Protection window, in CPU instructions
  localparam logic [2:0] RSCP_UNLOCK_INSTR = 3'h4;

  // Timing, in their own units, and cycle counts
  localparam int RSCP_CLK_MHZ = 200;
  localparam int RSCP_INIT_US = 250;
  localparam int RSCP_SCAN_US_PER_KB = 500;
  localparam int RSCP_SUT_US_PER_STEP = 1000;
  localparam int RSCP_INIT_CYC = RSCP_INIT_US * RSCP_CLK_MHZ;
  localparam int RSCP_SCAN_CYC = RSCP_SCAN_US_PER_KB * RSCP_CLK_MHZ;
  localparam int RSCP_SUT_CYC = RSCP_SUT_US_PER_STEP * RSCP_CLK_MHZ;

  // Controller states, one-hot
  typedef enum logic [2:0] {
    RSCP_RUN = 3'b001,
    RSCP_HOLD = 3'b010,
    RSCP_INIT = 3'b100
  } rscp_state_t;

  // Reset scope outputs, each active high
  typedef struct packed {
    logic core;
    logic debug_port;
    logic timer_override;
    logic dip_cfg;
    logic fuse_reload;
  } rscp_scope_t;

  // Raw request sources, before synchronising
  typedef struct packed {
    logic debug_port_req;
    logic watchdog_req;
    logic pin_low;
    logic supply_dip_req;
  } rscp_src_t;

endpackage : rscp_pkg

// file: src/rscp_ctrl.sv
// Reset source controller: merges six reset sources into scoped device resets.
// Assumes arst_n is the power-up reset and APB runs on the peripheral clock.
//
// Function
// - Always active; supply dip requests even if disabled
// - Cause flags record which source reset
// - After power-up only power-up flag set
// - Flags sticky, cleared by writing one
// - Power-up clears others, sets own flag
// - Power-up resets all, reloads fuses
// - Supply-dip reset spares dip cfg, fuses
// - Supply-dip detector forced on when unused
// - Trigger write starts reset until done
// - Software reset spares debug, timer, dip
// - Pin holds reset while low, enabled
// - Pin reset spares debug, timer, dip
// - Watchdog reset spares debug, timer, dip
// - Debug reset spares debug, timer, dip
// - Initialization time plus startup delay setting; power-up reset loads INIT_CYC alone
// - Boot scan adds time per kilobyte; not after power-up reset
// - Operates in active and sleep modes
// - Soft reset write needs key window
// - Trigger bit always reads zero
// - No other flag before boot completes
`timescale 1ns/1ps

module rscp_ctrl #(
  parameter int INIT_CYC = rscp_pkg::RSCP_INIT_CYC,
  parameter int SCAN_CYC = rscp_pkg::RSCP_SCAN_CYC,
  parameter int SUT_CYC = rscp_pkg::RSCP_SUT_CYC,
  parameter int SUT_W = 3,
  parameter int SCAN_KB_W = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources, asynchronous to clk
  input wire rscp_pkg::rscp_src_t src_raw,
  // Fuse and software enables
  input wire logic pin_reset_enable,
  input wire logic watchdog_enable,
  input wire logic debug_port_enable,
  input wire logic supply_dip_enable,
  input wire logic [SUT_W-1:0] startup_delay_setting,
  input wire logic boot_scan_source,
  input wire logic [SCAN_KB_W-1:0] boot_scan_kb,
  // Protection unlock: key written, and one pulse per CPU instruction
  input wire logic io_register_key,
  input wire logic cpu_instr_step,
  // Scoped resets and status
  output rscp_pkg::rscp_scope_t scope,
  output logic in_reset,
  output logic supply_dip_force_on
);
  import rscp_pkg::*;

  // Elaboration-time check of counts
  if (INIT_CYC < 1 || SCAN_CYC < 1 || SUT_CYC < 1 || SUT_W < 1 || SCAN_KB_W < 1) begin : g_chk
    $error("rscp_ctrl: counts and widths must be at least one");
  end

  localparam int NSRC = 4;

  // Agreement filter decision, used for every source
  function automatic logic agree_next(input logic cur, input logic s2, input logic s3);
    agree_next = (s2 == s3) ? s3 : cur;
  endfunction : agree_next

  logic [NSRC-1:0] raw_vec;
  logic [NSRC-1:0] sync1_q;
  logic [NSRC-1:0] sync2_q;
  logic [NSRC-1:0] sync3_q;
  logic [NSRC-1:0] clean_q; // Filtered source levels
  assign raw_vec = src_raw;

  // Three-stage synchronisers; first stage feeds only the second
  genvar gi;
  for (gi = 0; gi < NSRC; gi++) begin : g_sync
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sync1_q[gi] <= 1'b0;
        sync2_q[gi] <= 1'b0;
        sync3_q[gi] <= 1'b0;
        clean_q[gi] <= 1'b0;
      end else begin
        sync1_q[gi] <= raw_vec[gi];
        sync2_q[gi] <= sync1_q[gi];
        sync3_q[gi] <= sync2_q[gi];
        clean_q[gi] <= agree_next(clean_q[gi], sync2_q[gi], sync3_q[gi]);
      end
    end
  end

  // Source requests gated by their enables, except supply dip
  logic dip_req;
  logic pin_req;
  logic wdog_req;
  logic dbg_req;
  logic soft_req;
  assign dip_req = clean_q[0];
  assign pin_req = clean_q[1] & pin_reset_enable;
  assign wdog_req = clean_q[2] & watchdog_enable;
  assign dbg_req = clean_q[3] & debug_port_enable;

  // APB decode
  logic setup;
  logic access;
  logic hit_cause;
  logic hit_soft;
  logic wr_cause;
  logic wr_soft;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign hit_cause = (paddr == RSCP_ADDR_CAUSE);
  assign hit_soft = (paddr == RSCP_ADDR_SOFT);
  assign wr_cause = access & pwrite & hit_cause;
  assign wr_soft = access & pwrite & hit_soft;

  // Protection window counter
  logic [2:0] unlock_q; // Instructions left in the window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_q <= RSCP_UNLOCK_RESET;
    end else if (io_register_key) begin
      unlock_q <= RSCP_UNLOCK_INSTR;
    end else if (cpu_instr_step && unlock_q != 3'h0) begin
      unlock_q <= unlock_q - 3'h1;
    end
  end

  // Accepted trigger write; locked writes are silently dropped
  assign soft_req = wr_soft & pwdata[RSCP_BIT_TRIGGER] & (unlock_q != 3'h0);

  // Controller state
  rscp_state_t state_q;
  logic [31:0] cnt_q; // Initialization cycles left
  logic boot_done_q; // First full boot has finished
  logic any_req;
  logic [31:0] init_len;
  assign any_req = dip_req | pin_req | wdog_req | dbg_req | soft_req;

  // Initialization length: base, startup steps, optional scan
  always_comb begin
    init_len = 32'(INIT_CYC) + 32'(startup_delay_setting) * 32'(SUT_CYC);
    if (boot_scan_source) begin
      init_len = init_len + 32'(boot_scan_kb) * 32'(SCAN_CYC);
    end
  end

  // No sleep input exists: this never pauses in any mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= RSCP_INIT;
      cnt_q <= 32'(INIT_CYC);
    end else begin
      unique case (state_q)
        RSCP_RUN: begin
          if (any_req) begin
            state_q <= RSCP_HOLD;
          end
        end
        RSCP_HOLD: begin
          // Pin low keeps us here; soft pulse leaves at once
          if (!(dip_req | pin_req | wdog_req | dbg_req)) begin
            state_q <= RSCP_INIT;
            cnt_q <= init_len;
          end
        end
        RSCP_INIT: begin
          if (dip_req | pin_req | wdog_req | dbg_req) begin
            state_q <= RSCP_HOLD; // Source came back; restart
          end else if (cnt_q <= 32'h1) begin
            state_q <= RSCP_RUN;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        default: begin
          state_q <= RSCP_INIT;
          cnt_q <= 32'(INIT_CYC);
        end
      endcase
    end
  end

  // Boot completion marker, gates later flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_done_q <= 1'b0;
    end else if (state_q == RSCP_RUN) begin
      boot_done_q <= 1'b1;
    end
  end

  // Scope accumulation while in reset
  rscp_scope_t scope_q;
  rscp_scope_t scope_hit;
  always_comb begin
    scope_hit = '0;
    if (dip_req) begin
      scope_hit.core = 1'b1;
      scope_hit.debug_port = 1'b1;
      scope_hit.timer_override = 1'b1;
    end
    if (pin_req | wdog_req | dbg_req | soft_req) begin
      scope_hit.core = 1'b1;
    end
  end

  // Scope register: power-up sets everything, run clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scope_q <= '1;
    end else if (state_q == RSCP_RUN && !any_req) begin
      scope_q <= '0;
    end else begin
      scope_q <= scope_q | scope_hit; // Wider scope wins when sources overlap
    end
  end

  // Cause flags: set wins over write-one clear
  logic [5:0] cause_q;
  logic [5:0] cause_set;
  logic [5:0] cause_clr;
  always_comb begin
    cause_set = '0;
    cause_set[RSCP_BIT_SUPPLY_DIP] = dip_req;
    cause_set[RSCP_BIT_PIN] = pin_req;
    cause_set[RSCP_BIT_WATCHDOG] = wdog_req;
    cause_set[RSCP_BIT_SOFTWARE] = soft_req;
    cause_set[RSCP_BIT_DEBUG_PORT] = dbg_req;
    if (!boot_done_q) begin
      cause_set = '0;
    end
    cause_clr = wr_cause ? pwdata[5:0] : 6'h00;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_q <= RSCP_CAUSE_RESET;
    end else begin
      cause_q <= (cause_q & ~cause_clr) | cause_set;
    end
  end

  // APB answer: ready in the first access cycle, no wait states
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~(hit_cause | hit_soft);
      if (setup && hit_cause) begin
        prdata_q <= {26'h000_0000, cause_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Status outputs
  logic in_reset_q;
  logic force_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_reset_q <= 1'b1;
      force_q <= 1'b1;
    end else begin
      in_reset_q <= (state_q != RSCP_RUN) | any_req;
      force_q <= ~supply_dip_enable;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign scope = scope_q;
  assign in_reset = in_reset_q;
  assign supply_dip_force_on = force_q;

endmodule : rscp_ctrl

// file: dv/rscp_ctrl_props.sv
// Checker for the reset source controller, ports only.
// Bound into every rscp_ctrl instance; one clock domain.
`timescale 1ns/1ps
module rscp_ctrl_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rscp_pkg::rscp_src_t src_raw,
  input wire logic pin_reset_enable,
  input wire logic supply_dip_enable,
  input wire rscp_pkg::rscp_scope_t scope,
  input wire logic in_reset,
  input wire logic supply_dip_force_on
);
  import rscp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Zero wait states, answer stands one cycle
  chk_pready_setup: assert property (psel && !penable |=> pready) else $error("pready late");
  chk_pready_once: assert property (pready |=> !pready) else $error("pready stuck");
  chk_bad_addr: assert property (pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04)) else $error("pslverr");
  chk_trig_zero: assert property (pready && !pwrite && paddr == 8'h04 |-> prdata == 32'h0)
    else $error("trigger read");
  chk_flag_bits: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[31:6] == 26'h0)
    else $error("flag bits");
  // Low pin keeps the device held
  chk_pin_hold: assert property (in_reset && src_raw.pin_low && pin_reset_enable |=> in_reset)
    else $error("pin hold");
  chk_force_on: assert property (1'b1 |=> supply_dip_force_on == !$past(supply_dip_enable))
    else $error("force on");
  // Only power-up touches dip settings and fuses
  chk_dip_spared: assert property (!$rose(scope.dip_cfg)) else $error("dip cfg reset");
  chk_fuse_once: assert property (!$rose(scope.fuse_reload)) else $error("fuse reload");
  // Out of reset every scope line is released
  chk_scope_clear: assert property (!in_reset |-> scope == '0)
    else $error("scope left set");
  cover property (pready && pslverr);
  cover property ($rose(in_reset) && src_raw.pin_low);
  cover property ($rose(scope.debug_port));
endmodule : rscp_ctrl_props

bind rscp_ctrl rscp_ctrl_props u_props (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .src_raw, .pin_reset_enable, .supply_dip_enable, .scope, .in_reset, .supply_dip_force_on);

// file: dv/rscp_src_model.sv
// Far side: supply monitor, watchdog, reset pin, debug port.
// Bench commands levels; they change just after clk edges.
`timescale 1ns/1ps
module rscp_src_model (
  input wire logic clk,
  input wire logic [3:0] cmd,
  output rscp_pkg::rscp_src_t src_raw
);
  import rscp_pkg::*;
  initial src_raw = '0;
  // Each request is a level held while its cause lasts
  always @(posedge clk) begin
    src_raw.supply_dip_req <= cmd[0];
    src_raw.pin_low <= cmd[1];
    src_raw.watchdog_req <= cmd[2];
    src_raw.debug_port_req <= cmd[3];
  end
endmodule : rscp_src_model

// file: dv/test_reset_source_controller.sv
// Self-checking bench for the reset source controller.
// Assumes small init counts: 8 base, 2 per startup step, 4 per kilobyte.
// Scan on gives 18 init cycles, scan off gives 10.
`timescale 1ns/1ps
module test_reset_source_controller;
  import rscp_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, io_register_key, cpu_instr_step;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, in_reset, supply_dip_force_on, er;
  logic scan_on; // Boot scan extension select
  logic [3:0] cmd, en; // Source commands and enables
  rscp_src_t src_raw;
  rscp_scope_t scope;
  int miscompares = 0;
  int checks = 0;
  // Init length here: 8 + 1*2 + 2*4 = 18 cycles
  rscp_ctrl #(.INIT_CYC(8), .SCAN_CYC(4), .SUT_CYC(2)) uut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_raw, .pin_reset_enable(en[1]), .watchdog_enable(en[2]),
    .debug_port_enable(en[3]), .supply_dip_enable(en[0]), .startup_delay_setting(3'h1),
    .boot_scan_source(scan_on), .boot_scan_kb(4'h2), .io_register_key, .cpu_instr_step, .scope, .in_reset,
    .supply_dip_force_on);
  rscp_src_model u_src (.clk, .cmd, .src_raw);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_rst(input logic v);
    int n;
    n = 0;
    while (in_reset !== v) begin
      @(posedge clk);
      n++;
      if (n > 300) begin
        miscompares++;
        print_verdict();
      end
    end
  endtask : wait_rst

  task t_regs;
    apb(1'b0, 8'h00, 32'h0);
    chk("cause after power-up", rd, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("trigger read", rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped error", er, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("write zero keeps", rd, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk("write one clears", rd, 32'h0);
  endtask : t_regs

  // Locked, expired and unlocked soft reset writes
  task t_soft;
    apb(1'b1, 8'h04, 32'h1);
    repeat (8) @(posedge clk);
    chk("soft no key", in_reset, 1'b0);
    @(posedge clk) io_register_key <= 1'b1;
    @(posedge clk) io_register_key <= 1'b0;
    repeat (5) begin
      @(posedge clk) cpu_instr_step <= 1'b1;
      @(posedge clk) cpu_instr_step <= 1'b0;
    end
    apb(1'b1, 8'h04, 32'h1);
    repeat (8) @(posedge clk);
    chk("soft expired", in_reset, 1'b0);
    @(posedge clk) io_register_key <= 1'b1;
    @(posedge clk) io_register_key <= 1'b0;
    apb(1'b1, 8'h04, 32'h1);
    wait_rst(1'b1);
    repeat (2) @(posedge clk);
    chk("soft core", scope.core, 1'b1);
    chk("soft debug spared", scope.debug_port, 1'b0);
    chk("soft scope", scope, 32'h10);
    wait_rst(1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk("soft flag", rd, 32'h10);
    apb(1'b1, 8'h00, 32'h3f);
  endtask : t_soft

  // Each far-side source: disabled, then enabled and released
  task t_sources;
    int n;
    int exp_len;
    for (int i = 0; i < 4; i++) begin
      en <= 4'h0;
      cmd <= 4'h1 << i;
      scan_on <= (i < 2);
      exp_len = 8 + 1 * 2 + ((i < 2) ? 2 * 4 : 0);
      repeat (12) @(posedge clk);
      chk("disabled source", in_reset, i == 0);
      chk("forced on", supply_dip_force_on, 1'b1);
      en <= 4'hf;
      wait_rst(1'b1);
      repeat (22) @(posedge clk);
      chk("debug scope", scope.debug_port, i == 0);
      chk("held while active", in_reset, 1'b1);
      chk("source scope", scope, (i == 0) ? 32'h1c : 32'h10);
      @(posedge clk) cmd <= 4'h0;
      n = 0;
      while (in_reset === 1'b1 && n < 60) begin
        @(posedge clk);
        n++;
      end
      // Release path adds sync, agreement, hold exit and output flop cycles
      chk("init length", n >= exp_len + 7 && n <= exp_len + 9, 1'b1);
      apb(1'b0, 8'h00, 32'h0);
      chk("source flag", rd, 32'h1 << ((i == 3) ? 5 : i + 1));
      apb(1'b1, 8'h00, 32'h3f);
    end
  endtask : t_sources

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    io_register_key = 1'b0;
    cpu_instr_step = 1'b0;
    cmd = 4'h0;
    en = 4'hf;
    scan_on = 1'b1;
    repeat (6) @(posedge clk);
    chk("power-up scope", scope, 32'h1f);
    chk("power-up held", in_reset, 1'b1);
    arst_n <= 1'b1;
    wait_rst(1'b0);
    t_regs();
    t_soft();
    t_sources();
    print_verdict();
  end
endmodule : test_reset_source_controller
